// [bench/tsb_src.sv]
module tsb_src (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_send,
  input wire logic [3:0] i_valid,
  input wire logic [3:0] i_eop,
  input wire logic [3:0] i_err,
  input wire logic [3:0][3:0] i_empty,
  input wire logic [3:0] i_bctl,
  input wire logic [3:0][127:0] i_data,
  output logic [3:0] o_valid,
  output logic [3:0] o_eop,
  output logic [3:0] o_err,
  output logic [3:0][3:0] o_empty,
  output logic [3:0] o_bctl,
  output logic [3:0][127:0] o_data
);
  timeunit 1ns;
  timeprecision 1ps;
  // one transfer per send; outside it every qualified line drifts
  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n)
    begin
      {o_valid, o_eop, o_err, o_empty, o_bctl, o_data} <= '0;
    end
    else if (i_send)
    begin
      o_valid <= i_valid;
      o_eop <= i_eop;
      o_err <= i_err;
      o_empty <= i_empty;
      o_bctl <= i_bctl;
      o_data <= i_data;
    end
    else
    begin
      o_valid <= '0;
      {o_eop, o_err, o_empty, o_bctl, o_data} <= ~{o_eop, o_err, o_empty, o_bctl, o_data};
    end
  end
endmodule : tsb_src

// [bench/tx_segment_tail_and_burst_insert_tb_top.sv]
module tx_segment_tail_and_burst_insert_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [3:0] MV = 4'h7;
  localparam logic [3:0] ME = 4'hb;
  localparam logic [3:0] MR = 4'he;
  localparam logic [3:0] MB = 4'he;
  localparam logic [3:0][3:0] MT = {4'h5, 4'h7, 4'hd, 4'hf};
  logic i_clk = 0, i_rst_n = 0, psel = 0, pen = 0, pwr = 0, send = 0, pready, pslverr, e;
  logic [7:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, q;
  logic [3:0] sv = '0, se = '0, sr = '0, sb = '0, v, ee, r, b, ov, oe, oerr, ob;
  logic [3:0][3:0] sm = '0, m, om;
  logic [3:0][127:0] sd = '0, d, od;
  logic [127:0] x;
  int mismatches = 0, compares = 0, md;
  tsb_src src (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_send(send), .i_valid(sv), .i_eop(se),
    .i_err(sr), .i_empty(sm), .i_bctl(sb), .i_data(sd), .o_valid(v), .o_eop(ee), .o_err(r),
    .o_empty(m), .o_bctl(b), .o_data(d));
  tsb_top dut (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_psel(psel), .i_penable(pen),
    .i_pwrite(pwr), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready),
    .o_pslverr(pslverr), .i_seg_valid(v), .i_seg_eop(ee), .i_seg_err(r), .i_seg_empty(m),
    .i_seg_bctl(b), .i_seg_data(d), .o_seg_valid(ov), .o_seg_eop(oe), .o_seg_err(oerr),
    .o_seg_empty(om), .o_seg_bcw(ob), .o_seg_data(od));
  task automatic tally_and_finish();
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : tally_and_finish
  task automatic chk(input string nm, input logic [127:0] seen, input logic [127:0] exp);
    compares++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("[FAIL] %s exp %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
    int n;
    n = 0;
    @(posedge i_clk);
    {psel, pen, pwr, paddr, pwdata} <= {1'h1, 1'h0, w, a, wd};
    @(posedge i_clk);
    pen <= 1'h1;
    do
    begin
      @(posedge i_clk);
      n++;
    end
    while (pready !== 1'h1 && n < 20);
    q = prdata;
    e = pslverr;
    {psel, pen} <= 2'h0;
    if (n >= 20)
    begin
      mismatches++;
      tally_and_finish();
    end
  endtask : apb
  initial
  begin
    forever #2.5 i_clk = ~i_clk;
  end
  initial
  begin
    repeat (5) @(posedge i_clk);
    i_rst_n <= 1'h1;
    for (int rot = 0; rot < 4; rot++)
    begin
      @(posedge i_clk);
      for (int k = 0; k < 4; k++)
      begin
        md = (k + rot) % 4;
        {sv[k], se[k], sr[k], sb[k], sm[k]} <= {MV[md], ME[md], MR[md], MB[md], MT[md]};
        sd[k] <= {16{8'(k * 16 + rot)}};
      end
      send <= 1'h1;
      @(posedge i_clk);
      send <= 1'h0;
      @(posedge i_clk);
      #1;
      for (int k = 0; k < 4; k++)
      begin
        md = (k + rot) % 4;
        x = (MV[md] && ME[md]) ? (MR[md] ? {MT[md][3], 3'h0} : MT[md]) : 4'h0;
        chk("valid", ov[k], MV[md]);
        chk("eop", oe[k], MV[md] & ME[md]);
        chk("err", oerr[k], MV[md] & ME[md] & MR[md]);
        chk("empty", om[k], x);
        chk("bcw", ob[k], MV[md] & MB[md]);
        chk("data", od[k], MV[md] ? {16{8'(k * 16 + rot)}} : 128'h0);
      end
      @(posedge i_clk);
      #1;
      chk("idle ctl", {ov, oe, oerr, ob, om}, 128'h0);
      for (int k = 0; k < 4; k++)
      begin
        chk("idle data", od[k], 128'h0);
      end
    end
    $display("test segments done");
    apb(1'h0, 8'h00, 32'h0);
    chk("ctrl", q, 32'h1);
    chk("ctrl err", e, 1'h0);
    apb(1'h0, 8'h04, 32'h0);
    chk("bcw count", q, 32'h8);
    apb(1'h0, 8'h08, 32'h0);
    chk("err count", q, 32'h4);
    apb(1'h0, 8'h0c, 32'h0);
    chk("eop count", q, 32'h8);
    apb(1'h1, 8'h00, 32'h3);
    apb(1'h0, 8'h0c, 32'h0);
    chk("eop cleared", q, 32'h0);
    apb(1'h0, 8'h10, 32'h0);
    chk("unmapped err", e, 1'h1);
    chk("unmapped data", q, 32'h0);
    $display("test registers done");
    tally_and_finish();
  end
endmodule : tx_segment_tail_and_burst_insert_tb_top

// [src/tsb_pkg_seg.sv]
package tsb_pkg;
  localparam int NSEG = 4;
  localparam int DATA_W = 128;
  localparam int EMPTY_W = 4;
  localparam int EMPTY_LOW_W = 3;
  localparam int ADDR_W = 8;
  localparam logic [ADDR_W-1:0] OFS_CTRL = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_BCW_CNT = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_ERR_CNT = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_EOP_CNT = 8'h0c;
  localparam int CTRL_STATS_EN_BIT = 0;
  localparam int CTRL_CLEAR_BIT = 1;
  localparam logic CTRL_STATS_EN_RST = 1'b1;
  localparam logic [31:0] CNT_RST = 32'h0000_0000;
  localparam logic [EMPTY_W-1:0] EMPTY_RST = 4'h0;
  localparam logic [DATA_W-1:0] DATA_RST = '0;
endpackage : tsb_pkg

module tsb_seg (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_valid,
  input wire logic i_eop,
  input wire logic i_err,
  input wire logic [tsb_pkg::EMPTY_W-1:0] i_empty,
  input wire logic i_bctl,
  input wire logic [tsb_pkg::DATA_W-1:0] i_data,
  output logic o_valid,
  output logic o_eop,
  output logic o_err,
  output logic [tsb_pkg::EMPTY_W-1:0] o_empty,
  output logic o_bcw,
  output logic [tsb_pkg::DATA_W-1:0] o_data
);
  logic last_take;
  logic err_take;
  logic [tsb_pkg::EMPTY_W-1:0] empty_d;

  assign last_take = i_valid & i_eop;
  assign err_take = last_take & i_err;

  always_comb
  begin
    empty_d = tsb_pkg::EMPTY_RST;
    if (err_take)
    begin
      empty_d = {i_empty[tsb_pkg::EMPTY_W-1], {tsb_pkg::EMPTY_LOW_W{1'b0}}};
    end
    else if (last_take)
    begin
      empty_d = i_empty;
    end
  end

  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n)
    begin
      o_valid <= 1'b0;
      o_eop <= 1'b0;
      o_err <= 1'b0;
      o_empty <= tsb_pkg::EMPTY_RST;
      o_bcw <= 1'b0;
      o_data <= tsb_pkg::DATA_RST;
    end
    else
    begin
      o_valid <= i_valid;
      o_eop <= last_take;
      o_err <= err_take;
      o_empty <= empty_d;
      // burst word requested ahead of this data whenever the segment is valid and bctl is set
      o_bcw <= i_valid & i_bctl;
      o_data <= i_valid ? i_data : tsb_pkg::DATA_RST;
    end
  end
endmodule : tsb_seg

// [src/tsb_top.sv]
module tsb_top (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [tsb_pkg::ADDR_W-1:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  input wire logic [tsb_pkg::NSEG-1:0] i_seg_valid,
  input wire logic [tsb_pkg::NSEG-1:0] i_seg_eop,
  input wire logic [tsb_pkg::NSEG-1:0] i_seg_err,
  input wire logic [tsb_pkg::NSEG-1:0][tsb_pkg::EMPTY_W-1:0] i_seg_empty,
  input wire logic [tsb_pkg::NSEG-1:0] i_seg_bctl,
  input wire logic [tsb_pkg::NSEG-1:0][tsb_pkg::DATA_W-1:0] i_seg_data,
  output logic [tsb_pkg::NSEG-1:0] o_seg_valid,
  output logic [tsb_pkg::NSEG-1:0] o_seg_eop,
  output logic [tsb_pkg::NSEG-1:0] o_seg_err,
  output logic [tsb_pkg::NSEG-1:0][tsb_pkg::EMPTY_W-1:0] o_seg_empty,
  output logic [tsb_pkg::NSEG-1:0] o_seg_bcw,
  output logic [tsb_pkg::NSEG-1:0][tsb_pkg::DATA_W-1:0] o_seg_data
);
  logic stats_en_q;
  logic [31:0] bcw_cnt_q;
  logic [31:0] err_cnt_q;
  logic [31:0] eop_cnt_q;
  logic apb_access;
  logic apb_commit;
  logic wr_ctrl;
  logic clear_req;
  logic [31:0] rd_data;
  logic rd_err;

  function automatic logic [31:0] pop4(input logic [tsb_pkg::NSEG-1:0] v);
    logic [31:0] s;
    s = 32'h0;
    for (int i = 0; i < tsb_pkg::NSEG; i++)
    begin
      s = s + {31'h0, v[i]};
    end
    return s;
  endfunction : pop4

  genvar k;
  generate
    for (k = 0; k < tsb_pkg::NSEG; k++)
    begin : g_seg
      tsb_seg u_seg (
        .i_clk(i_clk),
        .i_rst_n(i_rst_n),
        .i_valid(i_seg_valid[k]),
        .i_eop(i_seg_eop[k]),
        .i_err(i_seg_err[k]),
        .i_empty(i_seg_empty[k]),
        .i_bctl(i_seg_bctl[k]),
        .i_data(i_seg_data[k]),
        .o_valid(o_seg_valid[k]),
        .o_eop(o_seg_eop[k]),
        .o_err(o_seg_err[k]),
        .o_empty(o_seg_empty[k]),
        .o_bcw(o_seg_bcw[k]),
        .o_data(o_seg_data[k])
      );
    end
  endgenerate

  // apb: one wait state, write and read complete at the edge where pready is seen
  assign apb_access = i_psel & i_penable & ~o_pready;
  assign apb_commit = i_psel & i_penable & o_pready;
  assign wr_ctrl = apb_commit & i_pwrite & (i_paddr == tsb_pkg::OFS_CTRL);
  assign clear_req = wr_ctrl & i_pwdata[tsb_pkg::CTRL_CLEAR_BIT];

  always_comb
  begin
    rd_data = 32'h0;
    rd_err = 1'b0;
    if (i_paddr == tsb_pkg::OFS_CTRL)
    begin
      rd_data = {31'h0, stats_en_q};
    end
    else if (i_paddr == tsb_pkg::OFS_BCW_CNT)
    begin
      rd_data = bcw_cnt_q;
    end
    else if (i_paddr == tsb_pkg::OFS_ERR_CNT)
    begin
      rd_data = err_cnt_q;
    end
    else if (i_paddr == tsb_pkg::OFS_EOP_CNT)
    begin
      rd_data = eop_cnt_q;
    end
    else
    begin
      rd_err = 1'b1;
    end
  end

  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n)
    begin
      o_pready <= 1'b0;
      o_pslverr <= 1'b0;
      o_prdata <= 32'h0;
    end
    else
    begin
      o_pready <= apb_access;
      o_pslverr <= apb_access & rd_err;
      o_prdata <= (apb_access & ~i_pwrite) ? rd_data : 32'h0;
    end
  end

  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n)
    begin
      stats_en_q <= tsb_pkg::CTRL_STATS_EN_RST;
    end
    else if (wr_ctrl)
    begin
      stats_en_q <= i_pwdata[tsb_pkg::CTRL_STATS_EN_BIT];
    end
  end

  // counters: events in the clearing cycle are still counted when stats_en_q is set
  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n)
    begin
      bcw_cnt_q <= tsb_pkg::CNT_RST;
      err_cnt_q <= tsb_pkg::CNT_RST;
      eop_cnt_q <= tsb_pkg::CNT_RST;
    end
    else
    begin
      bcw_cnt_q <= (clear_req ? tsb_pkg::CNT_RST : bcw_cnt_q)
        + (stats_en_q ? pop4(o_seg_bcw) : 32'h0);
      err_cnt_q <= (clear_req ? tsb_pkg::CNT_RST : err_cnt_q)
        + (stats_en_q ? pop4(o_seg_err) : 32'h0);
      eop_cnt_q <= (clear_req ? tsb_pkg::CNT_RST : eop_cnt_q)
        + (stats_en_q ? pop4(o_seg_eop) : 32'h0);
    end
  end

  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_rst_n);

  sequence s_apb_setup;
    i_psel && !i_penable;
  endsequence

  sequence s_apb_access;
    i_psel && i_penable && !o_pready;
  endsequence

  a_apb_one_wait: assert property (s_apb_setup ##1 s_apb_access |=> o_pready)
    else $error("apb answer not one cycle after access");

  a_apb_ready_pulse: assert property (o_pready |=> !o_pready)
    else $error("pready held longer than one cycle");

  a_err_with_ready: assert property (o_pslverr |-> o_pready)
    else $error("slave error without ready");

  // a clear with no end in that cycle leaves the end count at zero
  a_clear_count: assert property (clear_req && (o_seg_eop == '0) |=> eop_cnt_q == tsb_pkg::CNT_RST)
    else $error("end count not cleared");

  generate
    for (k = 0; k < tsb_pkg::NSEG; k++)
    begin : g_chk
      sequence s_last_ok;
        i_seg_valid[k] && i_seg_eop[k] && !i_seg_err[k];
      endsequence

      sequence s_last_err;
        i_seg_valid[k] && i_seg_eop[k] && i_seg_err[k];
      endsequence

      a_empty_passes: assert property (s_last_ok |=>
        o_seg_empty[k] == $past(i_seg_empty[k]) && o_seg_eop[k])
        else $error("empty count not passed on a good end");

      a_empty_ignored: assert property (!(i_seg_valid[k] && i_seg_eop[k]) |=>
        o_seg_empty[k] == tsb_pkg::EMPTY_RST && !o_seg_eop[k])
        else $error("empty count used outside a valid end");

      a_err_low_zero: assert property (s_last_err |=>
        o_seg_empty[k][tsb_pkg::EMPTY_LOW_W-1:0] == '0 && o_seg_err[k])
        else $error("low empty bits not forced on errored end");

      a_err_top_kept: assert property (s_last_err |=>
        o_seg_empty[k][tsb_pkg::EMPTY_W-1] == $past(i_seg_empty[k][tsb_pkg::EMPTY_W-1]))
        else $error("upper empty bit lost on errored end");

      a_bcw_forced: assert property (i_seg_valid[k] && i_seg_bctl[k] |=>
        o_seg_bcw[k] && o_seg_valid[k])
        else $error("forced burst word not requested");

      a_bcw_idle_off: assert property (!i_seg_valid[k] |=> !o_seg_bcw[k])
        else $error("burst word forced on an idle segment");

      a_err_gated: assert property (!(i_seg_valid[k] && i_seg_eop[k]) |=> !o_seg_err[k])
        else $error("error flagged outside a valid end");

      a_err_on_end: assert property (o_seg_err[k] |-> o_seg_eop[k] && o_seg_valid[k])
        else $error("error shown without a valid end");

      a_bcw_on_valid: assert property (o_seg_bcw[k] |-> o_seg_valid[k])
        else $error("burst word shown without valid data");

      a_data_word: assert property (i_seg_valid[k] |=>
        o_seg_data[k] == $past(i_seg_data[k]))
        else $error("segment data word not passed");
    end
  endgenerate
endmodule : tsb_top
